// File: ssp_peer.sv
// Far-side serial partner: slave to our master, master to our slave.
// Assumes the bench arms it between words with the mode bits.
module ssp_peer (
  // Pins seen from the far side
  input  wire logic i_sck,
  input  wire logic i_sdo,
  output logic      o_sdi,
  output logic      o_sck,
  output logic      o_ss_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        cke, clock_idle_polarity, w16, mst, on;
  logic [15:0] tx, rx;
  int          k, n;
  wire logic   sck_w;
  assign sck_w = mst ? i_sck : o_sck;

  initial begin
    on = 1'b0;
    mst = 1'b1;
    o_sdi = 1'b0;
    o_sck = 1'b0;
    o_ss_n = 1'b1;
  end

  // Mode bits {cke, ckp, w16, mst}
  task automatic arm(input logic [15:0] t, input logic [3:0] md);
    {cke, clock_idle_polarity, w16, mst} = md;
    on = 1'b0;
    o_sck = clock_idle_polarity;
    #1;
    tx = t;
    rx = 16'h0000;
    n = w16 ? 16 : 8;
    k = cke ? 1 : 0;
    o_sdi = cke ? t[n-1] : ~o_sdi;
    on = 1'b1;
  endtask

  // Change on one edge, sample on the other, MSB first
  always @(sck_w) begin
    if (on && ((sck_w != clock_idle_polarity) ^ cke)) begin
      if (k < n) o_sdi = tx[n-1-k];
      k++;
    end else if (on) begin
      rx = {rx[14:0], i_sdo};
    end
  end

  // Link clock runs only inside the frame
  task automatic frame();
    #9;
    o_ss_n = 1'b0;
    #160;
    repeat (2 * n) begin
      o_sck = ~o_sck;
      #80;
    end
    #80;
    o_ss_n = 1'b1;
    o_sdi = ~o_sdi;
  endtask
endmodule

// File: ssp_pkg.sv
// Package for the synchronous serial port, plus its pin synchroniser.
// Assumes a single core clock; pins arrive from outside that domain.
package ssp_pkg;
  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] SSP_OFS_STAT = 8'h00;
  localparam logic [7:0] SSP_OFS_CTRL = 8'h04;
  localparam logic [7:0] SSP_OFS_BUF  = 8'h08;
  localparam logic [7:0] SSP_OFS_IST  = 8'h0C;
  localparam logic [7:0] SSP_OFS_IMSK = 8'h10;
  // Status register field positions
  localparam int SSP_STAT_EN   = 15;
  localparam int SSP_STAT_SIDL = 13;
  localparam int SSP_STAT_ROV  = 6;
  localparam int SSP_STAT_TBF  = 1;
  localparam int SSP_STAT_RBF  = 0;
  // Control register field positions
  localparam int SSP_CTRL_W16  = 10;
  localparam int SSP_CTRL_CKE  = 8;
  localparam int SSP_CTRL_CKP  = 6;
  localparam int SSP_CTRL_MST  = 5;
  // Interrupt status/mask bit positions
  localparam int SSP_IRQ_RX    = 0;
  localparam int SSP_IRQ_TX    = 1;
  localparam int SSP_IRQ_OV    = 2;
  localparam int SSP_IRQ_W     = 3;
  // Shift register and transfer lengths
  localparam int          SSP_SR_W   = 16;
  localparam logic [4:0]  SSP_LEN16  = 5'h10;
  localparam logic [4:0]  SSP_LEN8   = 5'h08;
  localparam logic [15:0] SSP_RST16  = 16'h0000;
  localparam logic [31:0] SSP_RST32  = 32'h0000_0000;
  // Master shift clock half period
  localparam int SSP_CLK_NS      = 20;
  localparam int SSP_SCK_HALF_NS = 80;
  localparam int SSP_SCK_HALF_CYC =
    (SSP_SCK_HALF_NS / SSP_CLK_NS) < 1 ? 1 : SSP_SCK_HALF_NS / SSP_CLK_NS;

  typedef struct packed {
    logic w16;
    logic cke;
    logic clock_idle_polarity;
    logic mst;
  } ssp_ctrl_t;

  typedef enum logic [1:0] {
    SSP_S_IDLE = 2'b01,
    SSP_S_XFER = 2'b10
  } ssp_state_t;
endpackage

// Two-flop synchroniser for asynchronous pin inputs
module ssp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // Data
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_rst_val,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // Preload idle levels so no false select or edge follows reset
      meta_q <= i_rst_val;
      sync_q <= i_rst_val;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  // Reset value only masks the output until the first clock after reset
  logic fill_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fill_q <= 1'b0;
    end else begin
      fill_q <= 1'b1;
    end
  end
  assign o_sync = fill_q ? sync_q : i_rst_val;
endmodule

// File: ssp_top.sv
// Synchronous serial port with Wishbone classic register slave.
// Assumes pins are sampled by the core clock; no separate link domain.
//
// Operation
// - Data shifts through a hidden 16-bit register; software sees one buffer
// - Pins: serial data in, serial data out, shift clock, slave select low
// - Master drives the shift clock; slave receives it from outside
// - Enable bit runs the port and claims pins; clear disables it
// - Stop-in-idle bit halts the port while the device idles
// - New value arriving while buffer unread is dropped, sets overflow
// - CPU write to buffer loads transmit buffer and sets transmit full
// - Moving transmit buffer into shift register clears transmit full
// - Moving received value into receive buffer sets receive full
// - CPU read of buffer returns receive data and clears receive full
// - Unused status bits always read as zero
// - Width bit selects 16-bit transfers when set, 8-bit when clear
// - Polarity bit sets shift clock idle level; active is opposite
// - Edge bit picks which clock transition changes output data
// - Master bit selects master mode when set, slave when clear
//
// The Wishbone register port and the register addresses were decided locally.
module ssp_top
  import ssp_pkg::*;
#(
  parameter int ADR_W    = 8,
  parameter int HALF_CYC = SSP_SCK_HALF_CYC
) (
  // Clock and reset
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_RESET,
  // Device idle mode
  input  wire logic             I_IDLE,
  // Wishbone classic slave
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  input  wire logic             I_WB_WE,
  input  wire logic [ADR_W-1:0] I_WB_ADR,
  input  wire logic [3:0]       I_WB_SEL,
  input  wire logic [31:0]      I_WB_DAT,
  output logic      [31:0]      O_WB_DAT,
  output logic                  O_WB_ACK,
  // Serial pins
  input  wire logic             I_SDI,
  input  wire logic             I_SS_N,
  input  wire logic             I_SCK,
  output logic                  O_SCK,
  output logic                  O_SCK_OE_N,
  output logic                  O_SDO,
  output logic                  O_SDO_OE_N,
  // Interrupt
  output logic                  O_IRQ
);
  localparam int DIV_W = $clog2(HALF_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);

  function automatic logic msb_of(input logic [15:0] v, input logic w16);
    msb_of = w16 ? v[15] : v[7];
  endfunction

  function automatic logic [15:0] fit(input logic [15:0] v, input logic w16);
    fit = w16 ? v : {8'h00, v[7:0]};
  endfunction

  // Pin synchronisers
  logic sdi_s, ss_n_s, sck_s, sck_p_q, sck_p_d;
  ssp_sync #(.W(3)) u_sync (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_RESET),
    .i_async   ({I_SDI, I_SS_N, I_SCK}),
    .i_rst_val (3'b010),
    .o_sync    ({sdi_s, ss_n_s, sck_s})
  );

  // State
  ssp_ctrl_t        ctl_q, ctl_d;
  ssp_state_t       st_q, st_d;
  logic             en_q, en_d, sidl_q, sidl_d;
  logic             rov_q, rov_d, tbf_q, tbf_d, rbf_q, rbf_d;
  logic [15:0]      txb_q, txb_d, rxb_q, rxb_d, sr_q, sr_d;
  logic             samp_q, samp_d, out_q, out_d, sck_q, sck_d;
  logic [4:0]       cnt_q, cnt_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [SSP_IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d;
  logic             ack_q, ack_d;
  logic [31:0]      dat_q, dat_d;

  // Combinational helpers
  logic        run, lead, trail, acc, wr, rd, buf_rd, buf_wr, done;
  logic        ev_rx, ev_tx, ev_ov, rx_full;
  logic [4:0]  len;
  logic [15:0] wmask, shifted;

  always_comb begin
    ctl_d   = ctl_q;
    st_d    = st_q;
    en_d    = en_q;
    sidl_d  = sidl_q;
    rov_d   = rov_q;
    tbf_d   = tbf_q;
    rbf_d   = rbf_q;
    txb_d   = txb_q;
    rxb_d   = rxb_q;
    sr_d    = sr_q;
    samp_d  = samp_q;
    out_d   = out_q;
    sck_d   = sck_q;
    cnt_d   = cnt_q;
    div_d   = div_q;
    ist_d   = ist_q;
    imsk_d  = imsk_q;
    sck_p_d = sck_s;
    dat_d   = dat_q;
    lead    = 1'b0;
    trail   = 1'b0;
    done    = 1'b0;
    ev_rx   = 1'b0;
    ev_tx   = 1'b0;
    ev_ov   = 1'b0;
    shifted = SSP_RST16;

    // Bus: answer one cycle after the request, act on the ack edge
    ack_d  = I_WB_CYC & I_WB_STB & ~ack_q;
    acc    = I_WB_CYC & I_WB_STB & ack_q;
    wr     = acc & I_WB_WE;
    rd     = acc & ~I_WB_WE;
    wmask  = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
    buf_rd = rd & (I_WB_ADR == SSP_OFS_BUF[ADR_W-1:0]);
    buf_wr = wr & (I_WB_ADR == SSP_OFS_BUF[ADR_W-1:0]) & I_WB_SEL[0];
    rx_full = rbf_q & ~buf_rd;
    len     = ctl_q.w16 ? SSP_LEN16 : SSP_LEN8;
    run     = en_q & ~(sidl_q & I_IDLE);

    // Register read data, registered at the request edge
    if (ack_d) begin
      dat_d = SSP_RST32;
      unique case (I_WB_ADR)
        SSP_OFS_STAT[ADR_W-1:0]: begin
          dat_d[SSP_STAT_EN]   = en_q;
          dat_d[SSP_STAT_SIDL] = sidl_q;
          dat_d[SSP_STAT_ROV]  = rov_q;
          dat_d[SSP_STAT_TBF]  = tbf_q;
          dat_d[SSP_STAT_RBF]  = rbf_q;
        end
        SSP_OFS_CTRL[ADR_W-1:0]: begin
          dat_d[SSP_CTRL_W16] = ctl_q.w16;
          dat_d[SSP_CTRL_CKE] = ctl_q.cke;
          dat_d[SSP_CTRL_CKP] = ctl_q.clock_idle_polarity;
          dat_d[SSP_CTRL_MST] = ctl_q.mst;
        end
        SSP_OFS_BUF[ADR_W-1:0]:  dat_d[15:0] = rxb_q;
        SSP_OFS_IST[ADR_W-1:0]:  dat_d[SSP_IRQ_W-1:0] = ist_q;
        SSP_OFS_IMSK[ADR_W-1:0]: dat_d[SSP_IRQ_W-1:0] = imsk_q;
        default:                 dat_d = SSP_RST32;
      endcase
    end

    // Register writes; buffer-full flags have no write path
    if (wr && I_WB_ADR == SSP_OFS_STAT[ADR_W-1:0]) begin
      if (I_WB_SEL[1]) begin
        en_d   = I_WB_DAT[SSP_STAT_EN];
        sidl_d = I_WB_DAT[SSP_STAT_SIDL];
      end
      if (I_WB_SEL[0] && !I_WB_DAT[SSP_STAT_ROV]) begin
        rov_d = 1'b0;
      end
    end
    if (wr && I_WB_ADR == SSP_OFS_CTRL[ADR_W-1:0]) begin
      if (I_WB_SEL[1]) begin
        ctl_d.w16 = I_WB_DAT[SSP_CTRL_W16];
        ctl_d.cke = I_WB_DAT[SSP_CTRL_CKE];
      end
      if (I_WB_SEL[0]) begin
        ctl_d.clock_idle_polarity = I_WB_DAT[SSP_CTRL_CKP];
        ctl_d.mst = I_WB_DAT[SSP_CTRL_MST];
      end
    end
    if (wr && I_WB_ADR == SSP_OFS_IST[ADR_W-1:0] && I_WB_SEL[0]) begin
      ist_d = ist_q & ~I_WB_DAT[SSP_IRQ_W-1:0];
    end
    if (wr && I_WB_ADR == SSP_OFS_IMSK[ADR_W-1:0] && I_WB_SEL[0]) begin
      imsk_d = I_WB_DAT[SSP_IRQ_W-1:0];
    end
    if (buf_rd) begin
      rbf_d = 1'b0;
    end

    // Shift clock edges: timed by the divider or seen on the pin
    if (ctl_q.mst) begin
      if (st_q == SSP_S_XFER && run && div_q == DIV_LAST) begin
        lead  = (sck_q == ctl_q.clock_idle_polarity);
        trail = ~lead;
      end
    end else begin
      lead  = (sck_s ^ sck_p_q) & (sck_s != ctl_q.clock_idle_polarity);
      trail = (sck_s ^ sck_p_q) & (sck_s == ctl_q.clock_idle_polarity);
    end

    unique case (st_q)
      SSP_S_IDLE: begin
        div_d = '0;
        cnt_d = '0;
        if (ctl_q.mst) begin
          sck_d = ctl_q.clock_idle_polarity;
        end
        if (run && tbf_q) begin
          sr_d  = txb_q;
          out_d = msb_of(txb_q, ctl_q.w16);
          tbf_d = 1'b0;
          ev_tx = 1'b1;
          if (ctl_q.mst) begin
            st_d = SSP_S_XFER;
          end
        end
        if (run && !ctl_q.mst && !ss_n_s) begin
          st_d = SSP_S_XFER;
        end
      end
      SSP_S_XFER: begin
        if (run && ctl_q.mst) begin
          div_d = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
          if (div_q == DIV_LAST) begin
            sck_d = ~sck_q;
          end
        end
        if (run && !ctl_q.mst && ss_n_s) begin
          st_d  = SSP_S_IDLE;
          cnt_d = '0;
        end else if (run) begin
          // Edge bit: set shifts out on trailing, clear on leading
          if (ctl_q.cke) begin
            if (lead) begin
              samp_d = sdi_s;
            end
            if (trail) begin
              shifted = {sr_q[14:0], samp_q};
              sr_d    = shifted;
              out_d   = msb_of(shifted, ctl_q.w16);
              cnt_d   = cnt_q + 1'b1;
              done    = (cnt_q == len - 1'b1);
            end
          end else begin
            if (lead) begin
              out_d = msb_of(sr_q, ctl_q.w16);
            end
            if (trail) begin
              shifted = {sr_q[14:0], sdi_s};
              sr_d    = shifted;
              cnt_d   = cnt_q + 1'b1;
              done    = (cnt_q == len - 1'b1);
            end
          end
          if (done) begin
            cnt_d = '0;
            if (rx_full) begin
              rov_d = 1'b1;
              ev_ov = 1'b1;
            end else begin
              rxb_d = fit(shifted, ctl_q.w16);
              rbf_d = 1'b1;
              ev_rx = 1'b1;
            end
            if (ctl_q.mst) begin
              st_d = SSP_S_IDLE;
            end else if (tbf_q) begin
              // Slave chains straight into the next queued word
              sr_d  = txb_q;
              out_d = msb_of(txb_q, ctl_q.w16);
              tbf_d = 1'b0;
              ev_tx = 1'b1;
            end
          end
        end
      end
    endcase

    // CPU write wins over a same-cycle load, keeping the new word
    if (buf_wr) begin
      txb_d = (txb_q & ~wmask) | (I_WB_DAT[15:0] & wmask);
      tbf_d = 1'b1;
    end

    // Disabled port drops any transfer in flight
    if (!en_q) begin
      st_d  = SSP_S_IDLE;
      cnt_d = '0;
      div_d = '0;
      sck_d = ctl_q.clock_idle_polarity;
    end

    // Hardware set wins over software clear
    ist_d = ist_d | {ev_ov, ev_tx, ev_rx};
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      ctl_q   <= '0;
      st_q    <= SSP_S_IDLE;
      en_q    <= 1'b0;
      sidl_q  <= 1'b0;
      rov_q   <= 1'b0;
      tbf_q   <= 1'b0;
      rbf_q   <= 1'b0;
      txb_q   <= SSP_RST16;
      rxb_q   <= SSP_RST16;
      sr_q    <= SSP_RST16;
      samp_q  <= 1'b0;
      out_q   <= 1'b0;
      sck_q   <= 1'b0;
      cnt_q   <= '0;
      div_q   <= '0;
      ist_q   <= '0;
      imsk_q  <= '0;
      sck_p_q <= 1'b0;
      ack_q   <= 1'b0;
      dat_q   <= SSP_RST32;
    end else begin
      ctl_q   <= ctl_d;
      st_q    <= st_d;
      en_q    <= en_d;
      sidl_q  <= sidl_d;
      rov_q   <= rov_d;
      tbf_q   <= tbf_d;
      rbf_q   <= rbf_d;
      txb_q   <= txb_d;
      rxb_q   <= rxb_d;
      sr_q    <= sr_d;
      samp_q  <= samp_d;
      out_q   <= out_d;
      sck_q   <= sck_d;
      cnt_q   <= cnt_d;
      div_q   <= div_d;
      ist_q   <= ist_d;
      imsk_q  <= imsk_d;
      sck_p_q <= sck_p_d;
      ack_q   <= ack_d;
      dat_q   <= dat_d;
    end
  end

  // Outputs
  assign O_WB_DAT   = dat_q;
  assign O_WB_ACK   = ack_q;
  assign O_SCK      = sck_q;
  assign O_SCK_OE_N = ~(en_q & ctl_q.mst);
  assign O_SDO      = out_q;
  assign O_SDO_OE_N = ~(en_q & (ctl_q.mst | ~ss_n_s));
  assign O_IRQ      = |(ist_q & imsk_q);

  // Checks
  property p_tbf_set;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      buf_wr |=> tbf_q;
  endproperty
  a_tbf_set: assert property (p_tbf_set)
    else $error("transmit full not set after buffer write");

  property p_tbf_clr;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (ev_tx && !buf_wr) |=> !tbf_q && sr_q == $past(txb_q);
  endproperty
  a_tbf_clr: assert property (p_tbf_clr)
    else $error("transmit full not cleared on load");

  property p_rbf_set;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      ev_rx |=> rbf_q;
  endproperty
  a_rbf_set: assert property (p_rbf_set)
    else $error("receive full not set on completion");

  property p_rbf_clr;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (buf_rd && !ev_rx) |=> !rbf_q;
  endproperty
  a_rbf_clr: assert property (p_rbf_clr)
    else $error("receive full not cleared by read");

  property p_ovf;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (done && rx_full) |=> rov_q && $stable(rxb_q) && rbf_q;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow did not keep old data");

  property p_stat_zero;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (ack_d && !I_WB_WE && I_WB_ADR == SSP_OFS_STAT[ADR_W-1:0])
        |=> (O_WB_DAT & 32'hFFFF_5FBC) == 32'h0000_0000;
  endproperty
  a_stat_zero: assert property (p_stat_zero)
    else $error("unused status bits not zero");

  property p_disabled;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      !en_q |-> O_SCK_OE_N && O_SDO_OE_N ##1 (st_q == SSP_S_IDLE);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled port still active");

  property p_halt;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (en_q && sidl_q && I_IDLE && !buf_wr) |=> $stable(sr_q) && $stable(cnt_q);
  endproperty
  a_halt: assert property (p_halt)
    else $error("port moved while halted in idle");

  property p_sck_idle;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (en_q && ctl_q.mst && st_q == SSP_S_IDLE && $stable(ctl_q))
        |=> O_SCK == ctl_q.clock_idle_polarity;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("master clock not at idle level");

  property p_len;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      done |-> cnt_q == (ctl_q.w16 ? SSP_LEN16 : SSP_LEN8) - 5'h01;
  endproperty
  a_len: assert property (p_len)
    else $error("transfer length wrong");

  property p_cov_master;
    @(posedge I_CORE_CLK) disable iff (I_RESET) ev_rx && ctl_q.mst;
  endproperty
  c_cov_master: cover property (p_cov_master);

  property p_cov_slave;
    @(posedge I_CORE_CLK) disable iff (I_RESET) ev_rx && !ctl_q.mst;
  endproperty
  c_cov_slave: cover property (p_cov_slave);

  property p_cov_ovf;
    @(posedge I_CORE_CLK) disable iff (I_RESET) ev_ov;
  endproperty
  c_cov_ovf: cover property (p_cov_ovf);
endmodule

// File: tb_spi_serial_port_status.sv
// Bench for the serial port: registers, both modes, overflow, irq.
// Assumes the design files and the far-side model are compiled first.
module tb_spi_serial_port_status
  import ssp_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, idle, cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, q;
  wire  logic [31:0] rdat;
  wire  logic  ack, sdi, ss_n, p_sck, sck_pin;
  wire  logic  sck, sck_oe_n, sdo, sdo_oe_n, irq;
  int          err_count, num_checks, seed;
  assign sck_pin = sck_oe_n ? p_sck : sck;

  ssp_top uut (
    .I_CORE_CLK (clk),
    .I_RESET    (rst),
    .I_IDLE     (idle),
    .I_WB_CYC   (cyc),
    .I_WB_STB   (stb),
    .I_WB_WE    (we),
    .I_WB_ADR   (adr),
    .I_WB_SEL   (sel),
    .I_WB_DAT   (wdat),
    .O_WB_DAT   (rdat),
    .O_WB_ACK   (ack),
    .I_SDI      (sdi),
    .I_SS_N     (ss_n),
    .I_SCK      (sck_pin),
    .O_SCK      (sck),
    .O_SCK_OE_N (sck_oe_n),
    .O_SDO      (sdo),
    .O_SDO_OE_N (sdo_oe_n),
    .O_IRQ      (irq)
  );
  ssp_peer p (
    .i_sck  (sck_pin),
    .i_sdo  (sdo),
    .o_sdi  (sdi),
    .o_sck  (p_sck),
    .o_ss_n (ss_n)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic results();
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #1_000_000;
    err_count++;
    results();
  end

  // Classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask

  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, SSP_OFS_STAT, 32'h0000_0000);
      n++;
    end while (q[b] !== 1'b1 && n < 200);
    if (q[b] !== 1'b1) begin
      err_count++;
      results();
    end
  endtask

  task automatic load(input logic [3:0] md, input logic [15:0] t,
                      input logic [15:0] pw);
    p.arm(pw, md);
    // Back onto a rising edge before the bus request starts
    @(posedge clk);
    wb(1'b1, SSP_OFS_BUF, {16'h0000, t});
  endtask

  function automatic logic [31:0] cfg(input logic [3:0] md);
    cfg = 32'h0000_0000;
    cfg[SSP_CTRL_CKE] = md[3];
    cfg[SSP_CTRL_CKP] = md[2];
    cfg[SSP_CTRL_W16] = md[1];
    cfg[SSP_CTRL_MST] = md[0];
  endfunction

  initial begin
    logic [31:0] r;
    logic [15:0] tx, px, m;
    logic [3:0]  md;
    seed = 92;
    err_count = 0;
    num_checks = 0;
    rst = 1'b1;
    idle = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(SSP_OFS_STAT, 32'h0000_0000);
    rd_chk(SSP_OFS_IST, 32'h0000_0000);
    rd_chk(8'h14, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wb(1'b1, SSP_OFS_STAT, 32'h0000_FFFF);
    rd_chk(SSP_OFS_STAT, 32'h0000_A000);
    wb(1'b1, SSP_OFS_STAT, 32'h0000_0000);
    wb(1'b1, SSP_OFS_IMSK, 32'h0000_0001);
    // Every edge, polarity, width and role
    for (int i = 0; i < 16; i++) begin
      md = i[3:0];
      r = $random(seed);
      tx = r[15:0];
      px = r[31:16];
      m = md[1] ? 16'hFFFF : 16'h00FF;
      r = $random(seed);
      idle <= r[0];
      wb(1'b1, SSP_OFS_CTRL, cfg(md));
      load(md, tx, px);
      rd_chk(SSP_OFS_STAT, 32'h0000_0002);
      chk({30'h0, sck_oe_n, sdo_oe_n}, 32'h0000_0003);
      wb(1'b1, SSP_OFS_STAT, 32'h0000_8000);
      if (!md[0]) begin
        p.frame();
        @(posedge clk);
      end
      wait_bit(SSP_STAT_RBF);
      chk({31'h0, sck_oe_n}, {31'h0, !md[0]});
      chk({31'h0, irq}, 32'h0000_0001);
      if (md[0]) chk({31'h0, sck}, {31'h0, md[2]});
      rd_chk(SSP_OFS_BUF, {16'h0000, px & m});
      rd_chk(SSP_OFS_STAT, 32'h0000_8000);
      chk({16'h0000, p.rx & m}, {16'h0000, tx & m});
      rd_chk(SSP_OFS_IST, 32'h0000_0003);
      wb(1'b1, SSP_OFS_IST, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      wb(1'b1, SSP_OFS_IST, 32'h0000_0002);
      wb(1'b1, SSP_OFS_STAT, 32'h0000_0000);
    end
    // Second word arrives before the first is read
    md = 4'b0011;
    idle <= 1'b0;
    wb(1'b1, SSP_OFS_CTRL, cfg(md));
    wb(1'b1, SSP_OFS_IMSK, 32'h0000_0004);
    load(md, 16'h1234, 16'hA5C3);
    wb(1'b1, SSP_OFS_STAT, 32'h0000_8000);
    wait_bit(SSP_STAT_RBF);
    load(md, 16'h4321, 16'h3C5A);
    wait_bit(SSP_STAT_ROV);
    rd_chk(SSP_OFS_STAT, 32'h0000_8041);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(SSP_OFS_BUF, 32'h0000_A5C3);
    wb(1'b1, SSP_OFS_STAT, 32'h0000_8000);
    rd_chk(SSP_OFS_STAT, 32'h0000_8000);
    wb(1'b1, SSP_OFS_IST, 32'h0000_0007);
    // Halted while the device idles, resumes after
    idle <= 1'b1;
    wb(1'b1, SSP_OFS_STAT, 32'h0000_A000);
    load(md, 16'h0F0F, 16'h9696);
    repeat (40) @(posedge clk);
    rd_chk(SSP_OFS_STAT, 32'h0000_A002);
    idle <= 1'b0;
    wait_bit(SSP_STAT_RBF);
    rd_chk(SSP_OFS_BUF, 32'h0000_9696);
    chk({16'h0000, p.rx}, 32'h0000_0F0F);
    results();
  end
endmodule
